// ### logic/m16bm_master.sv
// Transaction engine for the multiplexed 16-bit address/data bus master.
// Overview of operation
// - Pause low blocks coprocessor transfers and new instructions.
// - Only bus owner starts; one transaction at once.
// - Bus claim: disconnect, release bus, then grant.
// - Interrupt request answered by acknowledge transaction.
// - Address strobe low then high; codes valid.
// - Acknowledge codes: A 0100, NMI 0101, B 0110, C 0111.
// - Memory 1000/1001 by cacheability; test-and-set 1111.
// - Template first 1101, next 1100; coprocessor-memory 1010.
// - Code 1110 carries no address; lines undefined.
// - Refresh 0001, I/O 0010, halt 0011.
// - Address valid at strobe rise with output enable.
// - Data strobe times data; refresh, halt never assert.
// - Write data driven, output enable held through strobe.
// - Reads float lines, input enable, sample before rise.
// - Wait sampled at falling edge; low adds cycles.
// - Programmed automatic wait cycles are inserted.
// - Memory transaction is three bus cycles unextended.
// - Odd bytes low lane, even bytes high lane.
// - Byte writes replicate byte on both lanes.
// - Words swapped: high byte on low lane.
// - Burst: one address strobe, data strobe held low over four beats, aligned.
// - Bursts only to regions marked burst-capable.
module m16bm_master #(
	parameter int AUTO_WAIT_W = m16bm_pkg::AUTO_WAIT_W
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   bus_width_strap,
	input  wire logic                   pause_n,
	input  wire logic                   wait_n,
	input  wire logic                   bus_claim_in_n,
	input  wire logic                   nmi_req_n,
	input  wire logic                   int_a_req_n,
	input  wire logic                   int_b_req_n,
	input  wire logic                   int_c_req_n,
	input  wire logic [AUTO_WAIT_W-1:0] auto_wait_cycles,
	input  wire logic [1:0]             burst_capable_half,
	input  wire logic                   req_valid,
	input  wire logic [3:0]             req_code,
	input  wire logic                   req_write,
	input  wire logic                   req_byte,
	input  wire logic                   req_burst,
	input  wire logic                   req_new_instr,
	input  wire logic [15:0]            req_addr,
	input  wire logic [15:0]            req_wdata,
	input  wire logic [15:0]            muxed_addr_data_lines_in,
	output logic                        req_ready,
	output logic                        rsp_valid,
	output logic                        rsp_err,
	output logic                        rsp_last,
	output logic [15:0]                 rsp_rdata,
	output logic                        address_strobe_n,
	output logic                        data_strobe_n,
	output logic [3:0]                  bus_cycle_type_code,
	output logic                        read_write_n,
	output logic                        byte_word,
	output logic                        output_enable_n,
	output logic                        input_direction_enable_n,
	output logic [15:0]                 muxed_addr_data_lines_out,
	output logic                        muxed_addr_data_lines_oe,
	output logic                        bus_ctrl_oe,
	output logic                        bus_grant_out_n,
	output logic                        bus_mode_16
);
	if (AUTO_WAIT_W < 2 || AUTO_WAIT_W > 8) begin : g_bad_width
		$error("auto wait width must be 2 to 8");
	end

	// Pin synchronisers: three flops, a change counts when stages two and three agree.
	logic [7:0] pin_raw;
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;
	logic [7:0] pin_s3_reg;
	logic [7:0] pin_q_reg;
	assign pin_raw = {bus_width_strap, pause_n, wait_n, bus_claim_in_n,
		nmi_req_n, int_c_req_n, int_b_req_n, int_a_req_n};
	genvar gi;
	generate
		for (gi = 0; gi < m16bm_pkg::PIN_COUNT; gi++) begin : g_sync
			// The strap stays out of reset so that its level is settled when reset ends.
			always_ff @(posedge clk) begin
				if (rst && gi != m16bm_pkg::PIN_COUNT - 1) begin
					pin_s1_reg[gi] <= m16bm_pkg::PIN_RESET[gi];
					pin_s2_reg[gi] <= m16bm_pkg::PIN_RESET[gi];
					pin_s3_reg[gi] <= m16bm_pkg::PIN_RESET[gi];
					pin_q_reg[gi]  <= m16bm_pkg::PIN_RESET[gi];
				end else begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
					if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
						pin_q_reg[gi] <= pin_s3_reg[gi];
					end
				end
			end
		end
	endgenerate

	wire int_a_q   = ~pin_q_reg[0];
	wire int_b_q   = ~pin_q_reg[1];
	wire int_c_q   = ~pin_q_reg[2];
	wire nmi_low_q = ~pin_q_reg[3];
	wire claim_q   = ~pin_q_reg[4];
	wire wait_q    = ~pin_q_reg[5];
	wire pause_q   = ~pin_q_reg[6];
	wire strap_q   = pin_q_reg[7];

	m16bm_pkg::m16bm_state_t state_reg;
	m16bm_pkg::m16bm_state_t state_next;
	logic                   ph_reg;
	logic                   mode_cap_reg;
	logic                   nmi_prev_reg;
	logic                   nmi_pend_reg;
	logic [3:0]             code_reg;
	logic                   wr_reg;
	logic                   byte_reg;
	logic                   burst_reg;
	logic                   iack_reg;
	logic [15:0]            addr_reg;
	logic [15:0]            wdata_reg;
	logic [AUTO_WAIT_W-1:0] wcnt_reg;
	logic [1:0]             beat_reg;

	// Bus width is caught once, on the first clock after reset is released.
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_cap_reg <= 1'b0;
			bus_mode_16  <= 1'b0;
		end else if (!mode_cap_reg) begin
			mode_cap_reg <= 1'b1;
			bus_mode_16  <= strap_q;
		end
	end

	// Request decode and acceptance.
	wire req_cop    = (req_code == m16bm_pkg::CODE_COP_MEM) ||
		(req_code == m16bm_pkg::CODE_TPL_NEXT) ||
		(req_code == m16bm_pkg::CODE_TPL_FIRST) ||
		(req_code == m16bm_pkg::CODE_COP_CPU);
	wire req_rsvd   = (req_code == m16bm_pkg::CODE_RESERVED_LO) ||
		(req_code == m16bm_pkg::CODE_RESERVED_HI);
	wire pause_ok   = !(pause_q && (req_cop || req_new_instr));
	wire in_idle    = (state_reg == m16bm_pkg::ST_IDLE);
	wire take       = in_idle && req_valid && req_ready && pause_ok;
	wire take_bus   = take && !req_rsvd;
	wire claim_go   = in_idle && !take && claim_q;
	wire nmi_fall   = nmi_low_q && !nmi_prev_reg;
	wire irq_any    = nmi_pend_reg || int_a_q || int_b_q || int_c_q;
	wire irq_go     = in_idle && !take && !claim_q && mode_cap_reg && irq_any;
	wire burst_ok   = req_burst && bus_mode_16 && !req_write && !req_byte &&
		burst_capable_half[req_addr[15]];

	// Acknowledge code by priority: NMI, then lines A, B, C.
	wire [3:0] irq_code = nmi_pend_reg ? m16bm_pkg::CODE_IACK_NMI :
		int_a_q ? m16bm_pkg::CODE_IACK_A :
		int_b_q ? m16bm_pkg::CODE_IACK_B : m16bm_pkg::CODE_IACK_C;

	wire no_data    = (code_reg == m16bm_pkg::CODE_REFRESH) ||
		(code_reg == m16bm_pkg::CODE_HALT);
	wire no_addr    = (code_reg == m16bm_pkg::CODE_COP_CPU);
	wire cop_data   = (code_reg == m16bm_pkg::CODE_COP_MEM);
	wire cyc_end    = ph_reg;
	wire hold_wait  = wait_q && !no_data;
	wire last_beat  = !burst_reg || (beat_reg == 2'(m16bm_pkg::BURST_BEATS - 1));
	wire t3_done    = (state_reg == m16bm_pkg::ST_T3) && cyc_end && !hold_wait;
	wire [AUTO_WAIT_W-1:0] iack_waits = auto_wait_cycles + AUTO_WAIT_W'(m16bm_pkg::IACK_MIN_WAITS);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			m16bm_pkg::ST_IDLE: begin
				if (take_bus || irq_go) begin
					state_next = m16bm_pkg::ST_T1;
				end else if (claim_go) begin
					state_next = m16bm_pkg::ST_DISC;
				end
			end
			m16bm_pkg::ST_T1: begin
				if (cyc_end) begin
					state_next = m16bm_pkg::ST_T2;
				end
			end
			m16bm_pkg::ST_T2: begin
				if (cyc_end) begin
					state_next = (wcnt_reg != '0) ? m16bm_pkg::ST_TA : m16bm_pkg::ST_T3;
				end
			end
			m16bm_pkg::ST_TA: begin
				if (cyc_end && wcnt_reg == AUTO_WAIT_W'(1)) begin
					state_next = m16bm_pkg::ST_T3;
				end
			end
			m16bm_pkg::ST_T3: begin
				if (t3_done) begin
					state_next = last_beat ? m16bm_pkg::ST_IDLE : m16bm_pkg::ST_T2;
				end
			end
			m16bm_pkg::ST_DISC: begin
				if (!claim_q) begin
					state_next = m16bm_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = m16bm_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= m16bm_pkg::ST_IDLE;
			ph_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			ph_reg    <= (state_next == m16bm_pkg::ST_IDLE || state_next == m16bm_pkg::ST_DISC ||
				state_next != state_reg) ? 1'b0 : ~ph_reg;
		end
	end

	// The NMI edge is held until its acknowledge starts; a new edge wins over the clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			nmi_prev_reg <= 1'b0;
			nmi_pend_reg <= 1'b0;
		end else begin
			nmi_prev_reg <= nmi_low_q;
			if (nmi_fall) begin
				nmi_pend_reg <= 1'b1;
			end else if (irq_go && nmi_pend_reg) begin
				nmi_pend_reg <= 1'b0;
			end
		end
	end

	// Transaction fields are loaded at start; the auto wait count runs on the first beat only.
	always_ff @(posedge clk) begin
		if (rst) begin
			code_reg  <= m16bm_pkg::CODE_MEM_CACHE;
			wr_reg    <= 1'b0;
			byte_reg  <= 1'b0;
			burst_reg <= 1'b0;
			iack_reg  <= 1'b0;
			addr_reg  <= 16'h0000;
			wdata_reg <= 16'h0000;
			wcnt_reg  <= '0;
			beat_reg  <= 2'h0;
		end else if (take_bus) begin
			code_reg  <= req_code;
			wr_reg    <= req_write;
			byte_reg  <= req_byte;
			burst_reg <= burst_ok;
			iack_reg  <= 1'b0;
			addr_reg  <= burst_ok ? {req_addr[15:3], 3'h0} : req_addr;
			wdata_reg <= req_wdata;
			wcnt_reg  <= auto_wait_cycles;
			beat_reg  <= 2'h0;
		end else if (irq_go) begin
			code_reg  <= irq_code;
			wr_reg    <= 1'b0;
			byte_reg  <= 1'b0;
			burst_reg <= 1'b0;
			iack_reg  <= 1'b1;
			wcnt_reg  <= iack_waits;
			beat_reg  <= 2'h0;
		end else if (state_reg == m16bm_pkg::ST_TA && cyc_end) begin
			wcnt_reg <= wcnt_reg - AUTO_WAIT_W'(1);
		end else if (t3_done && !last_beat) begin
			beat_reg <= beat_reg + 2'h1;
			wcnt_reg <= '0;
		end
	end

	// Pin view lags the state by one clock, so this edge closes the high half of T1.. T3.
	wire ds_span    = (state_reg == m16bm_pkg::ST_T2) || (state_reg == m16bm_pkg::ST_TA) ||
		(state_reg == m16bm_pkg::ST_T3);
	wire in_tx      = (state_reg == m16bm_pkg::ST_T1) || ds_span;
	wire as_low     = (state_reg == m16bm_pkg::ST_T1) && !ph_reg;
	wire ds_low     = ds_span && !no_data;
	wire drive_addr = (state_reg == m16bm_pkg::ST_T1) && !no_addr;
	wire drive_data = ds_low && wr_reg && !cop_data;
	wire read_in    = ds_low && !wr_reg && !cop_data;
	wire [15:0] wr_lanes = byte_reg ? {wdata_reg[7:0], wdata_reg[7:0]} :
		{wdata_reg[7:0], wdata_reg[15:8]};
	wire [15:0] ad_next  = drive_addr ? addr_reg : drive_data ? wr_lanes : 16'h0000;
	wire [15:0] rd_word  = {muxed_addr_data_lines_in[7:0], muxed_addr_data_lines_in[15:8]};
	wire [7:0]  rd_byte  = addr_reg[0] ? muxed_addr_data_lines_in[7:0] :
		muxed_addr_data_lines_in[15:8];

	always_ff @(posedge clk) begin
		if (rst) begin
			address_strobe_n          <= 1'b1;
			data_strobe_n             <= 1'b1;
			bus_cycle_type_code       <= m16bm_pkg::CODE_MEM_CACHE;
			read_write_n              <= 1'b1;
			byte_word                 <= 1'b0;
			output_enable_n           <= 1'b1;
			input_direction_enable_n  <= 1'b1;
			muxed_addr_data_lines_out <= 16'h0000;
			muxed_addr_data_lines_oe  <= 1'b0;
			bus_ctrl_oe               <= 1'b0;
			bus_grant_out_n           <= 1'b1;
		end else begin
			address_strobe_n          <= ~as_low;
			data_strobe_n             <= ~ds_low;
			if (in_tx) begin
				bus_cycle_type_code <= code_reg;
				read_write_n        <= ~wr_reg;
				byte_word           <= byte_reg;
			end
			output_enable_n           <= ~(drive_addr || drive_data);
			input_direction_enable_n  <= ~read_in;
			muxed_addr_data_lines_out <= ad_next;
			muxed_addr_data_lines_oe  <= drive_addr || drive_data;
			bus_ctrl_oe               <= (state_reg != m16bm_pkg::ST_DISC);
			bus_grant_out_n           <= ~((state_reg == m16bm_pkg::ST_DISC) && !bus_ctrl_oe);
		end
	end

	// Read data is taken at the falling edge that ends the strobe's last high half.
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_err   <= 1'b0;
			rsp_last  <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			req_ready <= (state_next == m16bm_pkg::ST_IDLE) && mode_cap_reg && !take;
			rsp_valid <= (t3_done && !iack_reg) || (take && req_rsvd);
			rsp_err   <= take && req_rsvd;
			rsp_last  <= (t3_done && last_beat && !iack_reg) || (take && req_rsvd);
			if (t3_done && !wr_reg && !no_data) begin
				rsp_rdata <= byte_reg ? {8'h00, rd_byte} : rd_word;
			end
		end
	end

	// Helper: count clocks from one address strobe fall to the next idle.
	logic [7:0] tx_len_reg;
	always_ff @(posedge clk) begin
		if (rst || state_reg == m16bm_pkg::ST_IDLE) begin
			tx_len_reg <= 8'h00;
		end else if (tx_len_reg != 8'hFF) begin
			tx_len_reg <= tx_len_reg + 8'h01;
		end
	end

	property p_code_legal;
		@(posedge clk) disable iff (rst) $fell(address_strobe_n) |->
			bus_cycle_type_code != 4'h0 && bus_cycle_type_code != 4'hB;
	endproperty
	a_code_legal: assert property (p_code_legal) else $error("reserved code driven");

	property p_as_pulse;
		@(posedge clk) disable iff (rst) $fell(address_strobe_n) |=> $rose(address_strobe_n) ##0
			$stable(bus_cycle_type_code) ##0 $stable(read_write_n);
	endproperty
	a_as_pulse: assert property (p_as_pulse) else $error("strobe or code not stable");

	property p_no_ds_refresh;
		@(posedge clk) disable iff (rst) !address_strobe_n && (bus_cycle_type_code == 4'h1 ||
			bus_cycle_type_code == 4'h3) |-> data_strobe_n [*8];
	endproperty
	a_no_ds_refresh: assert property (p_no_ds_refresh) else $error("strobe on no-data cycle");

	property p_addr_oe;
		@(posedge clk) disable iff (rst) !address_strobe_n && bus_cycle_type_code != 4'hE |->
			!output_enable_n && muxed_addr_data_lines_oe;
	endproperty
	a_addr_oe: assert property (p_addr_oe) else $error("address not driven");

	property p_read_float;
		@(posedge clk) disable iff (rst) !data_strobe_n && read_write_n |->
			!muxed_addr_data_lines_oe && output_enable_n;
	endproperty
	a_read_float: assert property (p_read_float) else $error("read lines not floated");

	property p_ie_read;
		@(posedge clk) disable iff (rst) !data_strobe_n && read_write_n &&
			bus_cycle_type_code != 4'hA |-> !input_direction_enable_n;
	endproperty
	a_ie_read: assert property (p_ie_read) else $error("input enable missing");

	property p_write_hold;
		@(posedge clk) disable iff (rst) !data_strobe_n && !read_write_n &&
			bus_cycle_type_code != 4'hA |-> !output_enable_n && muxed_addr_data_lines_oe;
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("write drive dropped");

	property p_grant_after_release;
		@(posedge clk) disable iff (rst) $fell(bus_grant_out_n) |-> !bus_ctrl_oe && !$past(bus_ctrl_oe);
	endproperty
	a_grant_after_release: assert property (p_grant_after_release) else $error("grant too early");

	property p_mem_len;
		@(posedge clk) disable iff (rst) t3_done && last_beat && !burst_reg && !iack_reg &&
			auto_wait_cycles == '0 && !$past(wait_q, 2) |-> tx_len_reg <= 8'd6;
	endproperty
	a_mem_len: assert property (p_mem_len) else $error("memory cycle too long");

	property p_wait_hold;
		@(posedge clk) disable iff (rst) state_reg == m16bm_pkg::ST_T3 && ph_reg && wait_q &&
			!no_data |=> state_reg == m16bm_pkg::ST_T3 ##1 state_reg == m16bm_pkg::ST_T3;
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait ignored");

	property p_one_tx;
		@(posedge clk) disable iff (rst) !bus_grant_out_n |-> !bus_ctrl_oe && address_strobe_n;
	endproperty
	a_one_tx: assert property (p_one_tx) else $error("bus used while granted");

	c_burst: cover property (@(posedge clk) disable iff (rst) rsp_valid && rsp_last && burst_reg);
	c_grant: cover property (@(posedge clk) disable iff (rst) $fell(bus_grant_out_n));
	c_iack:  cover property (@(posedge clk) disable iff (rst) $rose(address_strobe_n) &&
		bus_cycle_type_code == 4'h5);
endmodule : m16bm_master

// ### logic/m16bm_pkg.sv
// Constants shared by the multiplexed 16-bit bus master.
package m16bm_pkg;
	localparam logic [3:0] CODE_RESERVED_LO = 4'h0;
	localparam logic [3:0] CODE_REFRESH     = 4'h1;
	localparam logic [3:0] CODE_IO          = 4'h2;
	localparam logic [3:0] CODE_HALT        = 4'h3;
	localparam logic [3:0] CODE_IACK_A      = 4'h4;
	localparam logic [3:0] CODE_IACK_NMI    = 4'h5;
	localparam logic [3:0] CODE_IACK_B      = 4'h6;
	localparam logic [3:0] CODE_IACK_C      = 4'h7;
	localparam logic [3:0] CODE_MEM_CACHE   = 4'h8;
	localparam logic [3:0] CODE_MEM_NOCACHE = 4'h9;
	localparam logic [3:0] CODE_COP_MEM     = 4'hA;
	localparam logic [3:0] CODE_RESERVED_HI = 4'hB;
	localparam logic [3:0] CODE_TPL_NEXT    = 4'hC;
	localparam logic [3:0] CODE_TPL_FIRST   = 4'hD;
	localparam logic [3:0] CODE_COP_CPU     = 4'hE;
	localparam logic [3:0] CODE_TEST_SET    = 4'hF;

	// Clock edges per bus cycle: phase 0 is the high half, phase 1 the low half.
	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         BUS_CYCLE_NS     = 20;
	localparam int         BUS_CYCLE_CLKS   = BUS_CYCLE_NS / CLK_PERIOD_NS;
	localparam int         MEM_CYCLES       = 3;
	localparam int         BURST_BEATS      = 4;
	localparam logic [3:0] IACK_MIN_WAITS   = 4'h2;
	localparam int         AUTO_WAIT_W      = 4;
	localparam logic [2:0] BURST_ALIGN_MASK = 3'h7;
	localparam int         PIN_COUNT        = 8;
	localparam logic [7:0] PIN_RESET        = 8'h7F;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_T1   = 6'b000010,
		ST_T2   = 6'b000100,
		ST_TA   = 6'b001000,
		ST_T3   = 6'b010000,
		ST_DISC = 6'b100000
	} m16bm_state_t;
endpackage : m16bm_pkg

// ### bench/m16bm_mem_model.sv
// Memory on the far side of the multiplexed bus, able to stall through the wait line.
module m16bm_mem_model (
	input  wire logic        clk,
	input  wire logic        address_strobe_n,
	input  wire logic        data_strobe_n,
	input  wire logic        read_write_n,
	input  wire logic        byte_word,
	input  wire logic [15:0] ad_out,
	input  wire logic        ad_oe,
	input  wire logic [1:0]  beat,
	input  wire logic [3:0]  stall,
	output logic      [15:0] ad_in,
	output logic             wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic [15:0] addr_reg;
	logic [15:0] last_reg;
	logic [3:0]  cnt_reg;
	wire  [7:0]  ptr   = addr_reg[8:1] + {6'h00, beat};
	wire         drive = !data_strobe_n && read_write_n && !ad_oe;
	// A released bus shows the inverse of its last level, so stale data never matches.
	assign ad_in  = ad_oe ? ad_out : (drive ? mem[ptr] : ~last_reg);
	// Stalls count from the address strobe, so the master's pin synchroniser sees them in time.
	assign wait_n = !(stall != 4'h0 && (!address_strobe_n || cnt_reg < stall));
	initial begin
		last_reg = 16'h0000;
		cnt_reg = 4'hF;
		addr_reg = 16'h0000;
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h0000;
	end
	always @(posedge clk) begin
		last_reg <= ad_in;
		cnt_reg <= !address_strobe_n ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hF};
		if (!address_strobe_n && ad_oe)
			addr_reg <= ad_out;
		if (!data_strobe_n && !read_write_n && ad_oe) begin
			if (!byte_word)
				mem[ptr] <= ad_out;
			else if (addr_reg[0])
				mem[ptr][7:0] <= ad_out[7:0];
			else
				mem[ptr][15:8] <= ad_out[15:8];
		end
	end
endmodule : m16bm_mem_model

// ### bench/muxed_16bit_bus_master_tb.sv
// Self-checking bench for the multiplexed 16-bit bus master.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module muxed_16bit_bus_master_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        pause_n = 1'b1;
	logic        bus_width_strap = 1'b1;
	logic        req_new_instr = 1'b0;
	logic        bus_claim_in_n = 1'b1;
	logic        nmi_req_n = 1'b1;
	logic        int_a_req_n = 1'b1;
	logic        int_b_req_n = 1'b1;
	logic        int_c_req_n = 1'b1;
	logic [3:0]  stall = 4'h0;
	logic [3:0]  auto_wait_cycles = 4'h0;
	logic [1:0]  burst_capable_half = 2'h0;
	logic        req_valid = 1'b0;
	logic [3:0]  req_code = 4'h8;
	logic        req_write = 1'b0;
	logic        req_byte = 1'b0;
	logic        req_burst = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [15:0] req_wdata = 16'h0000;
	logic        wait_n, req_ready, rsp_valid, rsp_err, rsp_last, bus_mode_16;
	logic        address_strobe_n, data_strobe_n, read_write_n, byte_word;
	logic        output_enable_n, bus_ctrl_oe, bus_grant_out_n, muxed_addr_data_lines_oe;
	logic [3:0]  bus_cycle_type_code, code_q;
	logic [15:0] rsp_rdata, muxed_addr_data_lines_in, muxed_addr_data_lines_out;
	logic [15:0] addr_q, rd [0:3];
	logic        oe_q, oen_q, err_q, as_d, ds_d;
	int          mismatches, checked, as_cnt, ds_cnt, rsp_cnt, rsp_base, span, t, a0, n_last;
	wire  [1:0]  beat = 2'(rsp_cnt - rsp_base);

	m16bm_master i_dut (
		.clk, .rst, .bus_width_strap,
		.pause_n, .wait_n, .bus_claim_in_n, .nmi_req_n, .int_a_req_n, .int_b_req_n,
		.int_c_req_n, .auto_wait_cycles, .burst_capable_half, .req_valid, .req_code,
		.req_write, .req_byte, .req_burst, .req_new_instr, .req_addr, .req_wdata,
		.muxed_addr_data_lines_in, .req_ready, .rsp_valid, .rsp_err, .rsp_last,
		.rsp_rdata, .address_strobe_n, .data_strobe_n, .bus_cycle_type_code,
		.read_write_n, .byte_word, .output_enable_n, .input_direction_enable_n(),
		.muxed_addr_data_lines_out, .muxed_addr_data_lines_oe, .bus_ctrl_oe,
		.bus_grant_out_n, .bus_mode_16
	);
	m16bm_mem_model i_mem (
		.clk, .address_strobe_n, .data_strobe_n, .read_write_n, .byte_word,
		.ad_out(muxed_addr_data_lines_out), .ad_oe(muxed_addr_data_lines_oe), .beat,
		.stall, .ad_in(muxed_addr_data_lines_in), .wait_n
	);

	always #5 clk = ~clk;

	// The observer samples mid-cycle, once the design's edge updates have landed.
	always @(negedge clk) begin
		as_d <= address_strobe_n;
		ds_d <= data_strobe_n;
		t <= t + 1;
		if (as_d === 1'b1 && address_strobe_n === 1'b0)
			t <= 0;
		if (as_d === 1'b0 && address_strobe_n === 1'b1) begin
			as_cnt++;
			{code_q, addr_q} <= {bus_cycle_type_code, muxed_addr_data_lines_out};
			{oe_q, oen_q} <= {muxed_addr_data_lines_oe, output_enable_n};
		end
		if (ds_d === 1'b0 && data_strobe_n === 1'b1)
			span <= t + 1;
		if (ds_d === 1'b1 && data_strobe_n === 1'b0)
			ds_cnt++;
		if (rsp_valid === 1'b1) begin
			rd[beat] <= rsp_rdata;
			err_q <= rsp_err;
			rsp_cnt++;
			if (rsp_last === 1'b1)
				n_last++;
		end
	end

	task automatic xfer(input logic [3:0] c, input logic w, b, bst,
			input logic [15:0] a, d, input int beats);
		int k;
		logic rdy;
		k = 0;
		rsp_base = rsp_cnt;
		{req_code, req_write, req_byte, req_burst} <= {c, w, b, bst};
		{req_addr, req_wdata} <= {a, d};
		req_valid <= 1'b1;
		// Taken when ready is high at one edge and low at the next; a pause keeps it high.
		do begin
			rdy = (req_ready === 1'b1);
			@(posedge clk);
			k++;
		end while (!(rdy && req_ready !== 1'b1) && k < 100);
		req_valid <= 1'b0;
		while (rsp_cnt - rsp_base < beats && k < 300) begin
			@(posedge clk);
			k++;
		end
		repeat (4) @(posedge clk);
		`CHK(k < 300, 1'b1)
	endtask : xfer

	task automatic t_codes();
		logic [3:0] cs [10] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
		int d0;
		foreach (cs[i]) begin
			d0 = ds_cnt;
			xfer(cs[i], 1'b0, 1'b0, 1'b0, 16'h0040, 16'h0000, 1);
			`CHK(code_q, cs[i])
			if (cs[i] == 4'hE) begin
				`CHK(oe_q, 1'b0)
			end else if (cs[i] != 4'h1) begin
				`CHK(addr_q, 16'h0040)
				`CHK(oen_q, 1'b0)
			end
			`CHK(ds_cnt - d0, (cs[i] == 4'h1 || cs[i] == 4'h3) ? 0 : 1)
		end
	endtask : t_codes

	task automatic t_reserved();
		logic [3:0] cs [2] = '{4'h0, 4'hB};
		foreach (cs[i]) begin
			a0 = as_cnt;
			xfer(cs[i], 1'b0, 1'b0, 1'b0, 16'h0040, 16'h0000, 1);
			`CHK(err_q, 1'b1)
			`CHK(as_cnt, a0)
		end
	endtask : t_reserved

	task automatic t_data();
		xfer(4'h8, 1'b1, 1'b0, 1'b0, 16'h0100, 16'hA1B2, 1);
		`CHK(span, 6)
		xfer(4'h8, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0000, 1);
		`CHK(rd[0], 16'hA1B2)
		`CHK(span, 6)
		xfer(4'h8, 1'b0, 1'b1, 1'b0, 16'h0100, 16'h0000, 1);
		`CHK(rd[0][7:0], 8'hB2)
		xfer(4'h8, 1'b0, 1'b1, 1'b0, 16'h0101, 16'h0000, 1);
		`CHK(rd[0][7:0], 8'hA1)
		xfer(4'h8, 1'b1, 1'b1, 1'b0, 16'h0101, 16'h005C, 1);
		xfer(4'h8, 1'b1, 1'b1, 1'b0, 16'h0100, 16'h003D, 1);
		xfer(4'h8, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0000, 1);
		`CHK(rd[0], 16'h5C3D)
		auto_wait_cycles <= 4'h2;
		xfer(4'h8, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0000, 1);
		`CHK(span, 10)
		auto_wait_cycles <= 4'h0;
		stall <= 4'h4;
		xfer(4'h8, 1'b0, 1'b0, 1'b0, 16'h0100, 16'h0000, 1);
		`CHK(span > 6, 1'b1)
		`CHK(rd[0], 16'h5C3D)
		stall <= 4'h0;
	endtask : t_data

	task automatic t_burst();
		int l0;
		for (int i = 0; i < 4; i++)
			xfer(4'h8, 1'b1, 1'b0, 1'b0, 16'h0200 + 16'(2 * i), 16'(16'h1111 * (i + 1)), 1);
		burst_capable_half <= 2'h1;
		a0 = as_cnt;
		l0 = n_last;
		xfer(4'h8, 1'b0, 1'b0, 1'b1, 16'h0204, 16'h0000, 4);
		`CHK(as_cnt - a0, 1)
		`CHK(n_last - l0, 1)
		`CHK(addr_q, 16'h0200)
		for (int i = 0; i < 4; i++)
			`CHK(rd[i], 16'(16'h1111 * (i + 1)))
		xfer(4'h8, 1'b0, 1'b0, 1'b1, 16'h8206, 16'h0000, 1);
		`CHK(addr_q, 16'h8206)
		`CHK(rsp_cnt - rsp_base, 1)
	endtask : t_burst

	task automatic t_pause();
		for (int i = 0; i < 2; i++) begin
			a0 = as_cnt;
			pause_n <= 1'b0;
			req_new_instr <= (i == 1);
			repeat (6) @(posedge clk);
			fork
				begin
					repeat (20) @(posedge clk);
					`CHK(as_cnt, a0)
					pause_n <= 1'b1;
				end
			join_none
			xfer((i == 0) ? 4'hD : 4'h8, 1'b0, 1'b0, 1'b0, 16'h0040, 16'h0000, 1);
			`CHK(as_cnt, a0 + 1)
		end
		req_new_instr <= 1'b0;
	endtask : t_pause

	task automatic t_irq();
		logic [3:0] ex [4] = '{4'h4, 4'h6, 4'h7, 4'h5};
		int k;
		for (int i = 0; i < 4; i++) begin
			a0 = as_cnt;
			k = 0;
			{int_a_req_n, int_b_req_n, int_c_req_n, nmi_req_n} <= ~(4'h8 >> i);
			while (as_cnt == a0 && k < 100) begin
				@(posedge clk);
				k++;
			end
			{int_a_req_n, int_b_req_n, int_c_req_n, nmi_req_n} <= 4'hF;
			`CHK(code_q, ex[i])
			repeat (40) @(posedge clk);
		end
	endtask : t_irq

	task automatic t_claim();
		int k;
		k = 0;
		bus_claim_in_n <= 1'b0;
		while (bus_grant_out_n !== 1'b0 && k < 30) begin
			@(posedge clk);
			k++;
		end
		`CHK(bus_grant_out_n, 1'b0)
		`CHK(bus_ctrl_oe, 1'b0)
		`CHK(muxed_addr_data_lines_oe, 1'b0)
		bus_claim_in_n <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK(bus_grant_out_n, 1'b1)
		`CHK(bus_ctrl_oe, 1'b1)
	endtask : t_claim

	task automatic t_strap();
		bus_width_strap <= 1'b0;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(bus_mode_16, 1'b0)
		xfer(4'h8, 1'b0, 1'b0, 1'b1, 16'h0200, 16'h0000, 1);
		`CHK(rsp_cnt - rsp_base, 1)
	endtask : t_strap

	task automatic wrap_up();
		if (mismatches == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(bus_mode_16, 1'b1)
		t_codes();
		t_reserved();
		t_data();
		t_burst();
		t_pause();
		t_irq();
		t_claim();
		t_strap();
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
endmodule : muxed_16bit_bus_master_tb
